// ---- shared/cei_consts.svh ----
// Register offsets, field positions, reset values and thresholds
`ifndef CEI_CONSTS_SVH
`define CEI_CONSTS_SVH

// Byte addresses; status and control repeat every 16 bytes
`define CEI_ADDR_TX_ERR 8'h1C
`define CEI_ADDR_RX_ERR 8'h1D
`define CEI_ADDR_INT_EN 8'h2B
`define CEI_ADDR_INT_FLAG 8'h2C
`define CEI_ADDR_ERR_FLAG 8'h2D
`define CEI_LOW_CTRL 4'hF
`define CEI_LOW_STAT 4'hE

// Error flag register bits
`define CEI_EF_RX1OV 7
`define CEI_EF_RX0OV 6
`define CEI_EF_BOFF 5
`define CEI_EF_TX_ERROR_PASSIVE_FLAG 4
`define CEI_EF_RX_ERROR_PASSIVE_FLAG 3
`define CEI_EF_TXWR 2
`define CEI_EF_RXWR 1
`define CEI_EF_EWRN 0

// Interrupt enable and flag bits
`define CEI_IB_MERR 7
`define CEI_IB_WAKE 6
`define CEI_IB_ERR 5
`define CEI_IB_TX2 4
`define CEI_IB_TX1 3
`define CEI_IB_TX0 2
`define CEI_IB_RX1 1
`define CEI_IB_RX0 0

// Control register fields
`define CEI_CT_REQ_HI 7
`define CEI_CT_REQ_LO 5
`define CEI_CT_ABORT 4
`define CEI_CT_ONESHOT 3
`define CEI_CT_CLOCK_OUTPUT_ENABLE 2
`define CEI_CT_PRE_HI 1
`define CEI_CT_PRE_LO 0

// Status register fields
`define CEI_ST_MODE_HI 7
`define CEI_ST_MODE_LO 5
`define CEI_ST_CODE_HI 3
`define CEI_ST_CODE_LO 1

// Reset values
`define CEI_RST_CTRL 8'hE7
`define CEI_RST_ZERO 8'h00

// Error counter thresholds
`define CEI_LIM_WARN 8'h60
`define CEI_LIM_PASSIVE 8'h80
`define CEI_LIM_BUSOFF 8'hFF

`endif

// ---- shared/cei_pkg.sv ----
// Types shared by the error, interrupt and mode register bank
`default_nettype none
package cei_pkg;

    // Operating modes, same codes for request and status
    typedef enum logic [2:0] {
        CEI_MODE_NORMAL = 3'b000,
        CEI_MODE_SLEEP = 3'b001,
        CEI_MODE_LOOP = 3'b010,
        CEI_MODE_LISTEN = 3'b011,
        CEI_MODE_CONFIG = 3'b100
    } cei_mode_t;

    // Register access from the serial command decoder
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] data;
    } cei_hreq_t;

    // Single-cycle events from the protocol engine
    typedef struct packed {
        logic msg_err;
        logic wake;
        logic bus_recovered;
        logic [2:0] tx_empty;
        logic [1:0] rx_valid;
    } cei_evt_t;

    // Control levels toward the protocol engine
    typedef struct packed {
        logic [2:0] req_mode;
        logic abort_all;
        logic one_shot;
    } cei_ctrl_t;

endpackage
`default_nettype wire

// ---- rtl/cei_regs.sv ----
// Error, interrupt and operating mode register bank
`include "cei_consts.svh"
`default_nettype none
module cei_regs
    import cei_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    input wire cei_hreq_t hreq_i,
    input wire logic [1:0] rx_read_done_i,
    input wire logic [7:0] tx_err_count_i,
    input wire logic [7:0] rx_err_count_i,
    input wire cei_evt_t evt_i,
    input wire logic mode_switch_ok_i,
    output logic [7:0] reg_rdata_o,
    output cei_ctrl_t ctrl_o,
    output logic [2:0] mode_in_effect_o,
    output logic [7:0] int_flags_o,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_o
);

    // Bit-modify merge: masked bits take the new data
    function automatic logic [7:0] merge8(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] mask_v
    );
        merge8 = (old_v & ~mask_v) | (new_v & mask_v);
    endfunction

    // Registers of the bank
    logic [7:0] transmit_error_counter_q;
    logic [7:0] receive_error_counter_q;
    logic [7:0] interrupt_enable_register_q;
    logic [7:0] interrupt_flag_register_q;
    logic [7:0] interrupt_flag_register_d;
    logic rx_buffer1_overflow_q;
    logic rx_buffer0_overflow_q;
    logic bus_off_flag_q;
    logic [7:0] error_flag_register_prev_q;
    logic [2:0] mode_request_field_q;
    logic abort_all_pending_q;
    logic one_shot_transmit_q;
    logic clock_output_enable_q;
    logic [1:0] clock_output_prescaler_q;
    cei_mode_t operating_mode_status_q;
    logic [2:0] clk_div_q;
    logic clk_half_q;
    logic [7:0] rdata_q;

    // Derived flags and decode
    logic tx_warning_flag;
    logic rx_warning_flag;
    logic combined_warning_flag;
    logic tx_error_passive_flag;
    logic rx_error_passive_flag;
    logic [7:0] error_flag_register;
    logic [7:0] int_set;
    logic [7:0] int_live;
    logic [2:0] interrupt_code_field;
    logic [7:0] ctrl_word;
    logic [7:0] stat_word;
    logic wr_inte;
    logic wr_intf;
    logic wr_error_flag_register;
    logic wr_ctrl;

    // Write strobes; control repeats on every page, status has none
    assign wr_inte = hreq_i.wr && (hreq_i.addr == `CEI_ADDR_INT_EN);
    assign wr_intf = hreq_i.wr && (hreq_i.addr == `CEI_ADDR_INT_FLAG);
    assign wr_error_flag_register = hreq_i.wr && (hreq_i.addr == `CEI_ADDR_ERR_FLAG);
    assign wr_ctrl = hreq_i.wr && (hreq_i.addr[3:0] == `CEI_LOW_CTRL);

    // Error counters mirror the protocol engine
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_error_counter_q <= `CEI_RST_ZERO;
            receive_error_counter_q <= `CEI_RST_ZERO;
        end else if (soft_reset_i) begin
            transmit_error_counter_q <= `CEI_RST_ZERO;
            receive_error_counter_q <= `CEI_RST_ZERO;
        end else begin
            transmit_error_counter_q <= tx_err_count_i;
            receive_error_counter_q <= rx_err_count_i;
        end
    end

    // Threshold flags follow the counters with no memory
    assign tx_warning_flag =
        (transmit_error_counter_q >= `CEI_LIM_WARN);
    assign rx_warning_flag =
        (receive_error_counter_q >= `CEI_LIM_WARN);
    assign combined_warning_flag =
        tx_warning_flag | rx_warning_flag;
    assign tx_error_passive_flag =
        (transmit_error_counter_q >= `CEI_LIM_PASSIVE);
    assign rx_error_passive_flag =
        (receive_error_counter_q >= `CEI_LIM_PASSIVE);

    // Assembled error flag register
    always_comb begin
        error_flag_register = `CEI_RST_ZERO;
        error_flag_register[`CEI_EF_RX1OV] = rx_buffer1_overflow_q;
        error_flag_register[`CEI_EF_RX0OV] = rx_buffer0_overflow_q;
        error_flag_register[`CEI_EF_BOFF] = bus_off_flag_q;
        error_flag_register[`CEI_EF_TX_ERROR_PASSIVE_FLAG] = tx_error_passive_flag;
        error_flag_register[`CEI_EF_RX_ERROR_PASSIVE_FLAG] = rx_error_passive_flag;
        error_flag_register[`CEI_EF_TXWR] = tx_warning_flag;
        error_flag_register[`CEI_EF_RXWR] = rx_warning_flag;
        error_flag_register[`CEI_EF_EWRN] = combined_warning_flag;
    end

    // Bus-off is sticky until the engine reports recovery
    // Reaching 255 again in the recovery cycle keeps it set
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_off_flag_q <= 1'b0;
        end else if (soft_reset_i) begin
            bus_off_flag_q <= 1'b0;
        end else if (transmit_error_counter_q == `CEI_LIM_BUSOFF) begin
            bus_off_flag_q <= 1'b1;
        end else if (evt_i.bus_recovered) begin
            bus_off_flag_q <= 1'b0;
        end
    end

    // Overflow flags: host writes clear them, a new overflow wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_buffer1_overflow_q <= 1'b0;
            rx_buffer0_overflow_q <= 1'b0;
        end else if (soft_reset_i) begin
            rx_buffer1_overflow_q <= 1'b0;
            rx_buffer0_overflow_q <= 1'b0;
        end else begin
            if (evt_i.rx_valid[1] &&
                interrupt_flag_register_q[`CEI_IB_RX1]) begin
                rx_buffer1_overflow_q <= 1'b1;
            end else if (wr_error_flag_register && hreq_i.mask[`CEI_EF_RX1OV]) begin
                rx_buffer1_overflow_q <= hreq_i.data[`CEI_EF_RX1OV];
            end
            if (evt_i.rx_valid[0] &&
                interrupt_flag_register_q[`CEI_IB_RX0]) begin
                rx_buffer0_overflow_q <= 1'b1;
            end else if (wr_error_flag_register && hreq_i.mask[`CEI_EF_RX0OV]) begin
                rx_buffer0_overflow_q <= hreq_i.data[`CEI_EF_RX0OV];
            end
        end
    end

    // Previous error flags, to spot any change of condition
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            error_flag_register_prev_q <= `CEI_RST_ZERO;
        end else begin
            error_flag_register_prev_q <= error_flag_register;
        end
    end

    // Interrupt enable register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_enable_register_q <= `CEI_RST_ZERO;
        end else if (soft_reset_i) begin
            interrupt_enable_register_q <= `CEI_RST_ZERO;
        end else if (wr_inte) begin
            interrupt_enable_register_q <= merge8(
                interrupt_enable_register_q, hreq_i.data, hreq_i.mask);
        end
    end

    // Interrupt sources, each gated by its own enable
    always_comb begin
        int_set = `CEI_RST_ZERO;
        int_set[`CEI_IB_MERR] = evt_i.msg_err &
            interrupt_enable_register_q[`CEI_IB_MERR];
        int_set[`CEI_IB_WAKE] = evt_i.wake &
            interrupt_enable_register_q[`CEI_IB_WAKE];
        int_set[`CEI_IB_ERR] =
            (error_flag_register != error_flag_register_prev_q) &
            interrupt_enable_register_q[`CEI_IB_ERR];
        int_set[`CEI_IB_TX2] = evt_i.tx_empty[2] &
            interrupt_enable_register_q[`CEI_IB_TX2];
        int_set[`CEI_IB_TX1] = evt_i.tx_empty[1] &
            interrupt_enable_register_q[`CEI_IB_TX1];
        int_set[`CEI_IB_TX0] = evt_i.tx_empty[0] &
            interrupt_enable_register_q[`CEI_IB_TX0];
        int_set[`CEI_IB_RX1] = evt_i.rx_valid[1] &
            interrupt_enable_register_q[`CEI_IB_RX1];
        int_set[`CEI_IB_RX0] = evt_i.rx_valid[0] &
            interrupt_enable_register_q[`CEI_IB_RX0];
    end

    // Flag update: host write or fast read clears, a new event wins
    always_comb begin
        interrupt_flag_register_d = interrupt_flag_register_q;
        if (wr_intf) begin
            interrupt_flag_register_d = merge8(
                interrupt_flag_register_q, hreq_i.data, hreq_i.mask);
        end
        if (rx_read_done_i[1]) begin
            interrupt_flag_register_d[`CEI_IB_RX1] = 1'b0;
        end
        if (rx_read_done_i[0]) begin
            interrupt_flag_register_d[`CEI_IB_RX0] = 1'b0;
        end
        interrupt_flag_register_d =
            interrupt_flag_register_d | int_set;
    end

    // Interrupt flags hold until cleared
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_flag_register_q <= `CEI_RST_ZERO;
        end else if (soft_reset_i) begin
            interrupt_flag_register_q <= `CEI_RST_ZERO;
        end else begin
            interrupt_flag_register_q <= interrupt_flag_register_d;
        end
    end

    // Code of the highest priority enabled pending interrupt
    // Message error has no code of its own
    assign int_live =
        interrupt_flag_register_q & interrupt_enable_register_q;
    always_comb begin
        if (int_live[`CEI_IB_ERR]) begin
            interrupt_code_field = 3'h1;
        end else if (int_live[`CEI_IB_WAKE]) begin
            interrupt_code_field = 3'h2;
        end else if (int_live[`CEI_IB_TX0]) begin
            interrupt_code_field = 3'h3;
        end else if (int_live[`CEI_IB_TX1]) begin
            interrupt_code_field = 3'h4;
        end else if (int_live[`CEI_IB_TX2]) begin
            interrupt_code_field = 3'h5;
        end else if (int_live[`CEI_IB_RX0]) begin
            interrupt_code_field = 3'h6;
        end else if (int_live[`CEI_IB_RX1]) begin
            interrupt_code_field = 3'h7;
        end else begin
            interrupt_code_field = 3'h0;
        end
    end

    // Control register; reset request is the invalid code 111
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_request_field_q <= 3'(`CEI_RST_CTRL >> `CEI_CT_REQ_LO);
            abort_all_pending_q <= 1'b0;
            one_shot_transmit_q <= 1'b0;
            clock_output_enable_q <= 1'b1;
            clock_output_prescaler_q <= 2'h3;
        end else if (soft_reset_i) begin
            mode_request_field_q <= 3'(`CEI_RST_CTRL >> `CEI_CT_REQ_LO);
            abort_all_pending_q <= 1'b0;
            one_shot_transmit_q <= 1'b0;
            clock_output_enable_q <= 1'b1;
            clock_output_prescaler_q <= 2'h3;
        end else if (wr_ctrl) begin
            {mode_request_field_q, abort_all_pending_q,
             one_shot_transmit_q, clock_output_enable_q,
             clock_output_prescaler_q} <=
                merge8(ctrl_word, hreq_i.data, hreq_i.mask);
        end
    end

    assign ctrl_word = {mode_request_field_q, abort_all_pending_q,
        one_shot_transmit_q, clock_output_enable_q,
        clock_output_prescaler_q};

    // Mode in effect moves to the request when the engine allows
    // Undefined codes leave the mode where it is
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operating_mode_status_q <= CEI_MODE_CONFIG;
        end else if (soft_reset_i) begin
            operating_mode_status_q <= CEI_MODE_CONFIG;
        end else if (mode_switch_ok_i) begin
            unique case (mode_request_field_q)
                3'b000: operating_mode_status_q <= CEI_MODE_NORMAL;
                3'b001: operating_mode_status_q <= CEI_MODE_SLEEP;
                3'b010: operating_mode_status_q <= CEI_MODE_LOOP;
                3'b011: operating_mode_status_q <= CEI_MODE_LISTEN;
                3'b100: operating_mode_status_q <= CEI_MODE_CONFIG;
                default: begin
                    operating_mode_status_q <=
                        operating_mode_status_q;
                end
            endcase
        end
    end

    // Status register image
    always_comb begin
        stat_word = `CEI_RST_ZERO;
        stat_word[`CEI_ST_MODE_HI:`CEI_ST_MODE_LO] =
            operating_mode_status_q;
        stat_word[`CEI_ST_CODE_HI:`CEI_ST_CODE_LO] =
            interrupt_code_field;
    end

    // Free-running divider for the clock output
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_div_q <= 3'h0;
        end else begin
            clk_div_q <= clk_div_q + 3'h1;
        end
    end

    // Half-rate copy on the falling edge; no output uses it
    always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_half_q <= 1'b0;
        end else begin
            clk_half_q <= clk_div_q[0];
        end
    end

    // Divide by one passes the system clock itself
    always_comb begin
        unique case (clock_output_prescaler_q)
            2'h0: clock_output_pin_o = ref_clk_i;
            2'h1: clock_output_pin_o = clk_div_q[0];
            2'h2: clock_output_pin_o = clk_div_q[1];
            2'h3: clock_output_pin_o = clk_div_q[2];
        endcase
    end
    assign clock_output_pin_oe_o = clock_output_enable_q;

    // Read data registered; one cycle after the address
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= `CEI_RST_ZERO;
        end else if (hreq_i.addr[3:0] == `CEI_LOW_CTRL) begin
            rdata_q <= ctrl_word;
        end else if (hreq_i.addr[3:0] == `CEI_LOW_STAT) begin
            rdata_q <= stat_word;
        end else begin
            unique case (hreq_i.addr)
                `CEI_ADDR_TX_ERR: rdata_q <= transmit_error_counter_q;
                `CEI_ADDR_RX_ERR: rdata_q <= receive_error_counter_q;
                `CEI_ADDR_INT_EN: rdata_q <= interrupt_enable_register_q;
                `CEI_ADDR_INT_FLAG: rdata_q <= interrupt_flag_register_q;
                `CEI_ADDR_ERR_FLAG: rdata_q <= error_flag_register;
                default: rdata_q <= `CEI_RST_ZERO;
            endcase
        end
    end

    // Outputs toward the engine and the decoder
    assign reg_rdata_o = rdata_q;
    assign ctrl_o.req_mode = mode_request_field_q;
    assign ctrl_o.abort_all = abort_all_pending_q;
    assign ctrl_o.one_shot = one_shot_transmit_q;
    assign mode_in_effect_o = operating_mode_status_q;
    assign int_flags_o = interrupt_flag_register_q;

    // This sink only keeps the unused half-rate copy observed in lint
    logic unused_half;
    assign unused_half = clk_half_q;

endmodule
`default_nettype wire

// ---- tb/cei_regs_chk.sv ----
// Port-level assertions for the error, interrupt and mode register bank
`default_nettype none
module cei_regs_chk
    import cei_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    input wire cei_hreq_t hreq_i,
    input wire logic [1:0] rx_read_done_i,
    input wire logic [7:0] tx_err_count_i,
    input wire logic [7:0] rx_err_count_i,
    input wire logic mode_switch_ok_i,
    input wire logic [7:0] reg_rdata_o,
    input wire cei_ctrl_t ctrl_o,
    input wire logic [2:0] mode_in_effect_o,
    input wire logic [7:0] int_flags_o,
    input wire logic clock_output_pin_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i || soft_reset_i);

    // Counts pass through one register stage, then the read register
    a_tx_count_read: assert property (hreq_i.addr == 8'h1C && $past(rst_n_i, 2)
        |=> reg_rdata_o == $past(tx_err_count_i, 2)) else $error("tx count");
    a_rx_count_read: assert property (hreq_i.addr == 8'h1D && $past(rst_n_i, 2)
        |=> reg_rdata_o == $past(rx_err_count_i, 2)) else $error("rx count");
    // Level flags only judged once the count has stood for three edges
    a_tx_flag_level: assert property (hreq_i.addr == 8'h2D &&
        $stable(tx_err_count_i) && tx_err_count_i == $past(tx_err_count_i, 2)
        |=> {reg_rdata_o[4], reg_rdata_o[2]} == {$past(tx_err_count_i) >= 8'h80,
        $past(tx_err_count_i) >= 8'h60}) else $error("tx level flags");
    a_rx_flag_level: assert property (hreq_i.addr == 8'h2D &&
        $stable(rx_err_count_i) && rx_err_count_i == $past(rx_err_count_i, 2)
        |=> {reg_rdata_o[3], reg_rdata_o[1]} == {$past(rx_err_count_i) >= 8'h80,
        $past(rx_err_count_i) >= 8'h60}) else $error("rx level flags");
    a_warn_combined: assert property (hreq_i.addr == 8'h2D
        |=> reg_rdata_o[0] == (reg_rdata_o[2] | reg_rdata_o[1]))
        else $error("combined warning");
    // Only a host write or a fast read may take a pending flag away
    a_flag_holds: assert property (!(hreq_i.wr && hreq_i.addr == 8'h2C) &&
        rx_read_done_i == 2'b00 |=> (int_flags_o & $past(int_flags_o)) ==
        $past(int_flags_o)) else $error("interrupt flag lost");
    a_mode_follows: assert property (mode_switch_ok_i &&
        ctrl_o.req_mode <= 3'b100 |=> mode_in_effect_o == $past(ctrl_o.req_mode))
        else $error("mode not taken");
    a_mode_keeps: assert property (!(mode_switch_ok_i &&
        ctrl_o.req_mode <= 3'b100) |=> $stable(mode_in_effect_o))
        else $error("mode moved");
    a_ctrl_write: assert property (hreq_i.wr && hreq_i.addr[3:0] == 4'hF
        |=> ctrl_o == (($past(ctrl_o) & ~$past(hreq_i.mask[7:3])) |
        $past(hreq_i.data[7:3] & hreq_i.mask[7:3]))) else $error("control write");
    a_status_read: assert property (hreq_i.addr[3:0] == 4'hE |=>
        {reg_rdata_o[7:5], reg_rdata_o[4], reg_rdata_o[0]} ==
        {$past(mode_in_effect_o), 2'b00}) else $error("status read");
    // Enable may take one or two edges to reach the pin driver
    a_clk_oe_write: assert property (hreq_i.wr && hreq_i.addr[3:0] == 4'hF &&
        hreq_i.mask[2] ##1 !(hreq_i.wr && hreq_i.addr[3:0] == 4'hF) |->
        ##1 clock_output_pin_oe_o == $past(hreq_i.data[2], 2))
        else $error("clock enable");
endmodule

bind cei_regs cei_regs_chk i_cei_regs_chk (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i), .hreq_i(hreq_i),
    .rx_read_done_i(rx_read_done_i), .tx_err_count_i(tx_err_count_i),
    .rx_err_count_i(rx_err_count_i), .mode_switch_ok_i(mode_switch_ok_i),
    .reg_rdata_o(reg_rdata_o), .ctrl_o(ctrl_o),
    .mode_in_effect_o(mode_in_effect_o), .int_flags_o(int_flags_o),
    .clock_output_pin_oe_o(clock_output_pin_oe_o));
`default_nettype wire

// ---- tb/cei_host_model.sv ----
// Host side model: byte reads and masked writes as the decoder issues them
`default_nettype none
module cei_host_model
    import cei_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output cei_hreq_t hreq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial hreq_o = '0;

    // One strobe cycle per byte; data scrambled once the byte is taken
    task automatic wr_reg(input logic [7:0] a, d, m);
        @(posedge ref_clk_i);
        #1;
        if (a[3:0] == 4'hF && m[7:5] != 3'b000 && d[7:5] > 3'b100)
            d[7:5] = 3'b100; // Never an undefined mode code
        hreq_o = '{1'b1, a, m, d}; // Flags cleared by writes or by a fast read
        @(posedge ref_clk_i);
        #1;
        hreq_o.wr = 1'b0;
        hreq_o.data = ~d;
    endtask

    // Read data lands one edge after the address
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        hreq_o.addr = a;
        @(posedge ref_clk_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_cei_regs.sv ----
// Self-checking bench for the error, interrupt and mode register bank
`default_nettype none
module tb_cei_regs
    import cei_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic soft_rst = 1'b0;
    logic mode_ok = 1'b0;
    logic [1:0] rx_done = '0;
    logic [7:0] tx_cnt = '0;
    logic [7:0] rx_cnt = '0;
    logic [7:0] evt = '0;
    logic [7:0] rdata, flags, rd;
    logic [2:0] mode;
    logic clk_pin, clk_oe;
    cei_hreq_t hreq;
    cei_ctrl_t ctrl;
    int err_count = 0;
    int checks = 0;
    int edges = 0;
    bit count_on = 1'b0;

    always #25 ref_clk_i = ~ref_clk_i;
    always @(posedge clk_pin) if (count_on) edges++;

    cei_host_model i_cei_host_model (.ref_clk_i(ref_clk_i),
        .reg_rdata_i(rdata), .hreq_o(hreq));
    cei_regs i_cei_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .soft_reset_i(soft_rst), .hreq_i(hreq), .rx_read_done_i(rx_done),
        .tx_err_count_i(tx_cnt), .rx_err_count_i(rx_cnt),
        .evt_i(cei_evt_t'(evt)), .mode_switch_ok_i(mode_ok),
        .reg_rdata_o(rdata), .ctrl_o(ctrl), .mode_in_effect_o(mode),
        .int_flags_o(flags), .clock_output_pin_o(clk_pin),
        .clock_output_pin_oe_o(clk_oe));

    task automatic check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, exp);
        i_cei_host_model.rd_reg(a, rd);
        check($sformatf("register %h", a), rd, exp);
    endtask

    task automatic wr(input logic [7:0] a, d, m);
        i_cei_host_model.wr_reg(a, d, m);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Engine events, fast-read done and soft reset all last one cycle
    task automatic pulse(input logic [7:0] e, input logic [1:0] d,
                         input logic s = 1'b0);
        wait_cyc(1);
        {evt, rx_done, soft_rst} = {e, d, s};
        wait_cyc(1);
        {evt, rx_done, soft_rst} = '0;
    endtask

    function automatic logic [7:0] error_flag_register_lvl(input logic [7:0] t, r);
        return {3'b000, t >= 8'h80, r >= 8'h80, t >= 8'h60, r >= 8'h60,
            t >= 8'h60 || r >= 8'h60};
    endfunction

    // Error first, then wake, transmit 0..2, receive 0 and 1
    function automatic logic [2:0] icode(input logic [7:0] p);
        if (p[5]) return 3'd1;
        if (p[6]) return 3'd2;
        for (int i = 2; i < 5; i++) if (p[i]) return 3'(i + 1);
        if (p[0]) return 3'd6;
        if (p[1]) return 3'd7;
        return 3'd0;
    endfunction

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard well above the longest sequence
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        $display("unexpected run length: expected end, seen limit");
        wrap_up();
    end

    initial begin
        logic [7:0] t, r, f, e;
        logic [7:0] corner [8];
        corner = '{8'h00, 8'h5F, 8'h60, 8'h7F, 8'h80, 8'hFE, 8'h61, 8'h81};
        void'($urandom(877));
        wait_cyc(12);
        rst_n_i = 1'b1;
        // Reset values; writes to read-only places must vanish
        wr(8'h1C, 8'hFF, 8'hFF);
        wr(8'h3E, 8'hFF, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        rd_chk(8'h1D, 8'h00);
        rd_chk(8'h2C, 8'h00);
        rd_chk(8'h0F, 8'hE7);
        rd_chk(8'h3E, 8'h80);
        rd_chk(8'h30, 8'h00); // Unmapped place reads zero
        $display("test reset done");
        // Counter readback and level flags: corners, then random
        for (int i = 0; i < 24; i++) begin
            t = i < 8 ? corner[i] : 8'($urandom_range(254));
            r = i < 8 ? corner[7 - i] : 8'($urandom_range(254));
            {tx_cnt, rx_cnt} = {t, r};
            rd_chk(8'h1C, t);
            rd_chk(8'h1D, r);
            rd_chk(8'h2D, error_flag_register_lvl(t, r));
        end
        // Bus-off is sticky until the engine reports recovery
        {tx_cnt, rx_cnt} = {8'hFF, 8'h00};
        wait_cyc(1); // Bus-off sets one edge after the count lands
        rd_chk(8'h2D, 8'h20 | error_flag_register_lvl(8'hFF, 8'h00));
        tx_cnt = 8'h00;
        rd_chk(8'h2D, 8'h20);
        pulse(8'h20, 2'b00);
        rd_chk(8'h2D, 8'h00);
        $display("test error counters done");
        // Each engine event alone, then random events against random enables
        for (int i = 0; i < 30; i++) begin
            e = i < 8 ? 8'hFF : 8'($urandom);
            f = i < 8 ? 8'h01 << i : 8'($urandom);
            wr(8'h2B, e, 8'hFF);
            wr(8'h2C, 8'h00, 8'hFF);
            pulse(f, 2'b00);
            f = f & e & 8'hDF;
            rd_chk(8'h2C, f);
            check("flag port", flags, f);
            rd_chk(8'h0E, {3'b100, 1'b0, icode(f), 1'b0});
        end
        $display("test interrupt sources done");
        // Second message into a full buffer, then fast read clear
        wr(8'h2B, 8'h23, 8'hFF);
        wr(8'h2C, 8'h00, 8'hFF);
        pulse(8'h03, 2'b00);
        pulse(8'h02, 2'b00);
        rd_chk(8'h2D, 8'h80);
        rd_chk(8'h2C, 8'h23);
        pulse(8'h00, 2'b10);
        rd_chk(8'h2C, 8'h21);
        wr(8'h2D, 8'h00, 8'h80);
        rd_chk(8'h2D, 8'h00);
        wr(8'h2B, 8'h00, 8'hFF);
        $display("test overflow done");
        // Every mode code through mirrored control and status places
        mode_ok = 1'b1;
        for (int m = 4; m >= 0; m--) begin
            f = {3'(m), 2'($urandom), 3'b111};
            wr({4'($urandom), 4'hF}, f, 8'hFF);
            check("control port", {3'b000, ctrl}, {3'b000, f[7:3]});
            rd_chk({4'($urandom), 4'hE}, {3'(m), 5'b00000});
            check("mode port", {5'b0, mode}, {5'b0, 3'(m)});
        end
        $display("test modes done");
        // Divider codes measured as pin edges over 32 system cycles
        for (int c = 0; c < 4; c++) begin
            wr(8'h0F, {6'b000001, 2'(c)}, 8'h07);
            wait_cyc(2);
            {edges, count_on} = {32'd0, 1'b1};
            wait_cyc(32);
            count_on = 1'b0;
            check("clock edges", 8'(edges), 8'(32 >> c));
        end
        wr(8'h0F, 8'h00, 8'h04);
        wait_cyc(2);
        check("pin enable", {7'b0, clk_oe}, 8'h00);
        wr(8'h0F, 8'h04, 8'h04);
        wait_cyc(2);
        check("pin enable", {7'b0, clk_oe}, 8'h01);
        $display("test clock output done");
        // Soft reset brings back power-on control and status
        pulse(8'h00, 2'b00, 1'b1);
        rd_chk(8'h0F, 8'hE7);
        rd_chk(8'h0E, 8'h80);
        $display("test soft reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
